// >>> bench/dtc_event_source.sv
// Far-side model: drives the two counter input pins.
// Assumes the bench calls its tasks and the design samples on rising edges.
`timescale 1ns/1ps
`default_nettype none

module dtc_event_source (
  // Clock
  input  wire logic clock,
  // Driven pins
  output var logic  pin0,
  output var logic  pin1
);
  // ==========================================
  // Both pins rest low from time zero
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end

  // Change one pin at a falling edge so the rising edge sees it settled
  task automatic set_pin(input int ch, input logic v);
    @(negedge clock);
    if (ch == 0) begin
      pin0 = v;
    end else begin
      pin1 = v;
    end
  endtask

  // One pulse of n cycles at level v, then back to the other level
  task automatic pulse(input int ch, input logic v, input int n);
    set_pin(ch, v);
    repeat (n - 1) @(negedge clock);
    set_pin(ch, ~v);
  endtask
endmodule

`default_nettype wire

// >>> bench/dual_timer_event_counter_tb_top.sv
// Self-checking bench for the dual timer/event counter.
// Assumes dtc_pkg and the design modules are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_event_counter_tb_top;
  // ==========================================
  // Design connections and bench state
  logic              clock;
  logic              reset_n;
  dtc_pkg::dtc_bus_t bus_req;
  logic [7:0]        rdata;
  logic              pin0;
  logic              pin1;
  logic [1:0]        irq_enable;
  logic [1:0]        flag_clear;
  logic              flag0;
  logic              flag1;
  logic [1:0]        irq_request;
  logic              wake_up;
  logic [7:0]        rv;
  logic [7:0]        rh;
  int                err_count;
  int                checked;
  int                n;

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  dtc_top dut (
    .clock                  (clock),
    .reset_n                (reset_n),
    .bus_req                (bus_req),
    .rdata                  (rdata),
    .counter0_input         (pin0),
    .counter1_input         (pin1),
    .counter0_irq_enable    (irq_enable[0]),
    .counter1_irq_enable    (irq_enable[1]),
    .counter0_flag_clear    (flag_clear[0]),
    .counter1_flag_clear    (flag_clear[1]),
    .counter0_overflow_flag (flag0),
    .counter1_overflow_flag (flag1),
    .irq_request            (irq_request),
    .wake_up                (wake_up)
  );

  dtc_event_source src (
    .clock (clock),
    .pin0  (pin0),
    .pin1  (pin1)
  );

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe; the idle cycle after it avoids a double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clock);
    bus_req <= '0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clock);
    d = rdata;
    bus_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    check({8'h00, rv}, {8'h00, exp});
  endtask

  // Counter 1 read in the order that keeps both halves coherent
  task automatic rd16_chk(input logic [15:0] exp);
    rd(8'h0F, rh);
    rd(8'h10, rv);
    check({rh, rv}, exp);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    err_count = 0;
    checked = 0;
    reset_n = 1'b0;
    bus_req = '0;
    irq_enable = 2'h0;
    flag_clear = 2'h0;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    // Reset contents, unused bits, unmapped location
    rd_chk(8'h0E, 8'h08);
    rd_chk(8'h11, 8'h08);
    rd_chk(8'h20, 8'h00);
    wr(8'h0E, 8'hFF);
    rd_chk(8'h0E, 8'hD8);
    // Timer rate: 40 running cycles give exactly 10 ticks
    wr(8'h0E, 8'h80);
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h90);
    repeat (38) @(negedge clock);
    wr(8'h0E, 8'h80);
    rd_chk(8'h0D, 8'h0A);
    repeat (20) @(negedge clock);
    rd_chk(8'h0D, 8'h0A);
    // Overflow while a new preload waits for the reload
    wr(8'h0D, 8'hFD);
    rd_chk(8'h0D, 8'hFD);
    wr(8'h0E, 8'h90);
    wr(8'h0D, 8'h80);
    n = 0;
    while (flag0 !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    check({15'h0, flag0}, 16'h1);
    check({15'h0, wake_up}, 16'h1);
    wr(8'h0E, 8'h80);
    rd_chk(8'h0D, 8'h80);
    repeat (10) @(negedge clock);
    check({15'h0, flag0}, 16'h1);
    check({15'h0, wake_up}, 16'h0);
    check({14'h0, irq_request}, 16'h0);
    irq_enable = 2'h1;
    @(negedge clock);
    check({14'h0, irq_request}, 16'h1);
    flag_clear = 2'h1;
    @(negedge clock);
    flag_clear = 2'h0;
    @(negedge clock);
    check({15'h0, flag0}, 16'h0);
    // Counter 1 byte pairing and event counting
    wr(8'h11, 8'h40);
    wr(8'h10, 8'h34);
    rd16_chk(16'h0000);
    // The high read above overwrote the buffer, so fill it again
    wr(8'h10, 8'h34);
    wr(8'h0F, 8'h12);
    rd16_chk(16'h1234);
    wr(8'h11, 8'h50);
    repeat (3) src.pulse(1, 1'b1, 3);
    wr(8'h11, 8'h40);
    rd16_chk(16'h1237);
    // Falling polarity: the rise is ignored, the fall counts
    wr(8'h11, 8'h58);
    src.set_pin(1, 1'b1);
    repeat (3) @(negedge clock);
    rd16_chk(16'h1237);
    src.set_pin(1, 1'b0);
    repeat (3) @(negedge clock);
    rd16_chk(16'h1238);
    // Counter 1 overflow keeps run-enable set
    wr(8'h11, 8'h48);
    wr(8'h10, 8'hFE);
    wr(8'h0F, 8'hFF);
    wr(8'h11, 8'h58);
    repeat (2) src.pulse(1, 1'b1, 3);
    repeat (2) @(negedge clock);
    check({15'h0, flag1}, 16'h1);
    check({14'h0, irq_request}, 16'h0);
    irq_enable = 2'h2;
    @(negedge clock);
    check({14'h0, irq_request}, 16'h2);
    rd_chk(8'h11, 8'h58);
    rd16_chk(16'hFFFE);
    // Pulse width: a level already high must not start a measurement
    wr(8'h0D, 8'h00);
    src.set_pin(0, 1'b1);
    wr(8'h0E, 8'hD0);
    repeat (20) @(negedge clock);
    rd_chk(8'h0D, 8'h00);
    src.set_pin(0, 1'b0);
    repeat (4) @(negedge clock);
    src.pulse(0, 1'b1, 40);
    repeat (4) @(negedge clock);
    rd_chk(8'h0E, 8'hC0);
    rd(8'h0D, rh);
    check({15'h0, (rh >= 8'h09 && rh <= 8'h0B)}, 16'h1);
    src.pulse(0, 1'b1, 40);
    repeat (4) @(negedge clock);
    rd_chk(8'h0D, rh);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// >>> hw/dtc_edge_detect.sv
// Transition detector for one counter input pin.
// Assumes the pin is already synchronous to the clock.
`default_nettype none
`timescale 1ns/1ps

module dtc_edge_detect (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Pin and polarity
  input  wire logic pin,
  input  wire logic edge_pol,
  // Detected transitions
  output logic      active_edge,
  output logic      return_edge
);

  // ==========================================================
  // Previous level
  logic prior;        // Pin level one cycle ago
  logic prior_valid;  // Prior holds a real sample

  // The valid flag stops a high pin at reset faking a rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prior       <= 1'b0;
      prior_valid <= 1'b0;
    end else begin
      prior       <= pin;
      prior_valid <= 1'b1;
    end
  end

  // Rising when polarity is 0, falling when 1
  logic rise;
  logic fall;
  assign rise        = prior_valid && !prior && pin;
  assign fall        = prior_valid && prior && !pin;
  assign active_edge = edge_pol ? fall : rise;
  assign return_edge = edge_pol ? rise : fall;

endmodule

`default_nettype wire

// >>> hw/dtc_pkg.sv
// Constants and carrier types for the dual timer/event counter block.
// Assumes a single 40 MHz system clock and an active-low async reset.
//
// Functional notes
// - Run-enable bit 4 stops or allows counting.
// - Edge bit 3: 0 rising, 1 falling.
// - Mode bits 7:6: 01 event, 10 timer, 11 pulse.
// - Control bits 0-2 and 5 read zero.
// - Timer and pulse modes count clock divided by four.
// - Counter 0 write loads preload, read returns count.
// - Low write buffers; high write loads 16-bit preload.
// - High read returns high, captures low into buffer.
// - Count up to all ones, then reload preload.
// - Overflow sets its request flag same cycle.
// - Pulse mode counts between edges, clears run-enable.
// - One pulse measurement per run-enable setting.
// - Pulse measurement starts on an edge, not level.
// - Pulse-mode overflow reloads and flags like others.
// - Event and timer modes never self-clear run-enable.
// - Overflow offered as a wake-up source.
// - Cleared interrupt enable blocks overflow service.
// - Stopped counter copies preload writes immediately.
// - Running counter takes new preload at overflow.
// - Counting clock blocked while a counter is read.
// - Counter 0 control uses counter 1 layout.
`default_nettype none

package dtc_pkg;

  // ==========================================================
  // Register locations in data memory
  localparam logic [7:0] ADDR_C0_VALUE   = 8'h0D;
  localparam logic [7:0] ADDR_C0_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_C1_HIGH    = 8'h0F;
  localparam logic [7:0] ADDR_C1_LOW     = 8'h10;
  localparam logic [7:0] ADDR_C1_CONTROL = 8'h11;

  // ==========================================================
  // Control register fields and reset value
  localparam int         CTRL_EDGE_BIT  = 3;
  localparam int         CTRL_RUN_BIT   = 4;
  localparam int         CTRL_MODE_LO   = 6;
  localparam int         CTRL_MODE_HI   = 7;
  localparam logic [7:0] CTRL_RESET     = 8'h08;
  localparam logic [7:0] CTRL_READ_MASK = 8'hD8;

  // Mode field codes; code 00 leaves the counter idle
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_EVENT  = 2'h1;
  localparam logic [1:0] MODE_TIMER  = 2'h2;
  localparam logic [1:0] MODE_PULSE  = 2'h3;

  // ==========================================================
  // Counter limits and reset contents
  localparam logic [15:0] C0_MAX      = 16'h00FF;
  localparam logic [15:0] C1_MAX      = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Internal time base divides the system clock by this figure
  localparam int         TICK_DIV      = 4;
  localparam logic [1:0] TICK_LAST     = 2'(TICK_DIV - 1);

  // ==========================================================
  // Register port request from the processor core
  typedef struct packed {
    logic [7:0] addr;   // Data memory address
    logic       wr;     // One-cycle write strobe
    logic       rd;     // One-cycle read strobe
    logic [7:0] wdata;  // Write data
  } dtc_bus_t;

  // Decoded control register contents
  typedef struct packed {
    logic [1:0] mode;      // Operating mode
    logic       run;       // Run-enable
    logic       edge_pol;  // Edge polarity, 1 selects falling
  } dtc_ctrl_t;

endpackage

`default_nettype wire

// >>> hw/dtc_time_base.sv
// Divide-by-four tick for the timer and pulse modes.
// Assumes the system clock drives it directly, free running.
`default_nettype none
`timescale 1ns/1ps

module dtc_time_base (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Tick out, one cycle in four
  output logic      tick
);

  // ==========================================================
  // Phase counter
  logic [1:0] phase;  // Position within the divide period

  // Free running so every counter shares one time base
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Single reference time base, no prescaler choice
  assign tick = (phase == dtc_pkg::TICK_LAST);

endmodule

`default_nettype wire

// >>> hw/dtc_top.sv
// Two count-up timer/event counters behind data-memory registers.
// Assumes one-cycle read and write strobes from the core, pins
// synchronous to the clock, and flag clears from interrupt control.
`default_nettype none
`timescale 1ns/1ps

module dtc_top (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Register port
  input  wire dtc_pkg::dtc_bus_t bus_req,
  output logic [7:0]             rdata,
  // Counter input pins
  input  wire logic              counter0_input,
  input  wire logic              counter1_input,
  // Interrupt control bits
  input  wire logic              counter0_irq_enable,
  input  wire logic              counter1_irq_enable,
  input  wire logic              counter0_flag_clear,
  input  wire logic              counter1_flag_clear,
  output logic                   counter0_overflow_flag,
  output logic                   counter1_overflow_flag,
  output logic [1:0]             irq_request,
  output logic                   wake_up
);

  // ==========================================================
  // Channel state, index 0 is the 8-bit counter
  dtc_pkg::dtc_ctrl_t ctrl    [2];  // Control fields
  logic [15:0]        count   [2];  // Live counter
  logic [15:0]        preload [2];  // Reload value
  logic [1:0]         pw_active;    // Pulse measurement running
  logic [1:0]         flag;         // Sticky overflow flags
  logic [7:0]         low_buf;      // Counter 1 low-byte buffer

  // Per-channel strobes and helpers
  logic [1:0]  tick_hit;
  logic [1:0]  start_edge;
  logic [1:0]  end_edge;
  logic [1:0]  ctl_wr;
  logic [1:0]  pre_wr;
  logic [1:0]  value_rd;
  logic [1:0]  step;
  logic [1:0]  ovf;
  logic [1:0]  flag_clear;
  logic [15:0] pre_val [2];
  logic        tick;

  // ==========================================================
  // Helper functions

  // Top value for a channel
  function automatic logic [15:0] count_max(input logic idx);
    return idx ? dtc_pkg::C1_MAX : dtc_pkg::C0_MAX;
  endfunction

  // Whether a channel advances this cycle
  function automatic logic count_step(input dtc_pkg::dtc_ctrl_t c,
                                      input logic tk,
                                      input logic ev,
                                      input logic pw,
                                      input logic blocked);
    logic go;
    go = 1'b0;
    unique case (c.mode)
      dtc_pkg::MODE_EVENT: go = ev;
      dtc_pkg::MODE_TIMER: go = tk;
      dtc_pkg::MODE_PULSE: go = pw && tk;
      default:             go = 1'b0;
    endcase
    return c.run && !blocked && go;
  endfunction

  // Control register as read back, reserved bits zero
  function automatic logic [7:0] ctrl_read(input dtc_pkg::dtc_ctrl_t c);
    logic [7:0] v;
    v = 8'h00;
    v[dtc_pkg::CTRL_MODE_HI:dtc_pkg::CTRL_MODE_LO] = c.mode;
    v[dtc_pkg::CTRL_RUN_BIT]  = c.run;
    v[dtc_pkg::CTRL_EDGE_BIT] = c.edge_pol;
    return v & dtc_pkg::CTRL_READ_MASK;
  endfunction

  // ==========================================================
  // Shared time base and input edge detectors
  dtc_time_base u_time_base (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick)
  );

  dtc_edge_detect u_edge0 (
    .clock       (clock),
    .reset_n     (reset_n),
    .pin         (counter0_input),
    .edge_pol    (ctrl[0].edge_pol),
    .active_edge (start_edge[0]),
    .return_edge (end_edge[0])
  );

  dtc_edge_detect u_edge1 (
    .clock       (clock),
    .reset_n     (reset_n),
    .pin         (counter1_input),
    .edge_pol    (ctrl[1].edge_pol),
    .active_edge (start_edge[1]),
    .return_edge (end_edge[1])
  );

  // ==========================================================
  // Address decode
  logic wr_c1_low;
  logic rd_c1_high;
  logic rd_c1_low;
  assign wr_c1_low  = bus_req.wr && (bus_req.addr == dtc_pkg::ADDR_C1_LOW);
  assign rd_c1_high = bus_req.rd && (bus_req.addr == dtc_pkg::ADDR_C1_HIGH);
  assign rd_c1_low  = bus_req.rd && (bus_req.addr == dtc_pkg::ADDR_C1_LOW);

  // Same control layout on both channels
  assign ctl_wr[0] = bus_req.wr && (bus_req.addr == dtc_pkg::ADDR_C0_CONTROL);
  assign ctl_wr[1] = bus_req.wr && (bus_req.addr == dtc_pkg::ADDR_C1_CONTROL);

  // Counter 0 write goes to its preload, and to the counter too while stopped
  assign pre_wr[0]  = bus_req.wr && (bus_req.addr == dtc_pkg::ADDR_C0_VALUE);
  assign pre_val[0] = {8'h00, bus_req.wdata};

  // Only a high-byte write moves data into the 16-bit preload
  assign pre_wr[1]  = bus_req.wr && (bus_req.addr == dtc_pkg::ADDR_C1_HIGH);
  assign pre_val[1] = {bus_req.wdata, low_buf};

  // Any counter data read blocks that counter's clock
  assign value_rd[0] = bus_req.rd && (bus_req.addr == dtc_pkg::ADDR_C0_VALUE);
  assign value_rd[1] = rd_c1_high || rd_c1_low;

  assign flag_clear = {counter1_flag_clear, counter0_flag_clear};
  assign tick_hit   = {tick, tick};

  // ==========================================================
  // Step and overflow decisions
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // A read in progress suppresses this cycle's count
      step[i] = count_step(ctrl[i], tick_hit[i], start_edge[i],
                           pw_active[i], value_rd[i]);
      // All ones is the last value before reload
      ovf[i]  = step[i] && (count[i] == count_max(1'(i)));
    end
  end

  // ==========================================================
  // Control registers
  // A software write beats the hardware clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        // Fields taken from the documented reset byte
        ctrl[i].mode     <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_MODE_HI:
                                                dtc_pkg::CTRL_MODE_LO];
        ctrl[i].run      <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_RUN_BIT];
        ctrl[i].edge_pol <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_EDGE_BIT];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctl_wr[i]) begin
          // Mode, run-enable and polarity from the written byte
          ctrl[i].mode     <= bus_req.wdata[dtc_pkg::CTRL_MODE_HI:
                                            dtc_pkg::CTRL_MODE_LO];
          ctrl[i].run      <= bus_req.wdata[dtc_pkg::CTRL_RUN_BIT];
          ctrl[i].edge_pol <= bus_req.wdata[dtc_pkg::CTRL_EDGE_BIT];
        end else if (ctrl[i].mode == dtc_pkg::MODE_PULSE && pw_active[i]
                     && end_edge[i]) begin
          // Measurement done, hardware drops run-enable
          ctrl[i].run <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Pulse measurement state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pw_active <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!ctrl[i].run || ctrl[i].mode != dtc_pkg::MODE_PULSE) begin
          // Cleared run-enable ignores later edges
          pw_active[i] <= 1'b0;
        end else if (!pw_active[i] && start_edge[i]) begin
          // Only a transition starts the measurement
          pw_active[i] <= 1'b1;
        end else if (end_edge[i]) begin
          // Input back at its original level
          pw_active[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Preload registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        preload[i] <= dtc_pkg::COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pre_wr[i]) begin
          preload[i] <= pre_val[i];
        end
      end
    end
  end

  // ==========================================================
  // Counters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        count[i] <= dtc_pkg::COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pre_wr[i] && !ctrl[i].run) begin
          // Stopped: the write lands in the counter too
          count[i] <= pre_val[i];
        end else if (ovf[i]) begin
          // Reload in every mode, new preload only here
          count[i] <= preload[i];
        end else if (step[i]) begin
          count[i] <= count[i] + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Counter 1 low-byte buffer, shared by writes and reads
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      low_buf <= 8'h00;
    end else if (wr_c1_low) begin
      low_buf <= bus_req.wdata;
    end else if (rd_c1_high) begin
      // Snapshot so the pair reads coherently
      low_buf <= count[1][7:0];
    end
  end

  // ==========================================================
  // Read data, held until the next read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        dtc_pkg::ADDR_C0_VALUE:   rdata <= count[0][7:0];
        dtc_pkg::ADDR_C0_CONTROL: rdata <= ctrl_read(ctrl[0]);
        dtc_pkg::ADDR_C1_HIGH:    rdata <= count[1][15:8];
        dtc_pkg::ADDR_C1_LOW:     rdata <= low_buf;
        dtc_pkg::ADDR_C1_CONTROL: rdata <= ctrl_read(ctrl[1]);
        default:                  rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Overflow flags and wake-up
  // Set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag    <= 2'h0;
      wake_up <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ovf[i]) begin
          flag[i] <= 1'b1;
        end else if (flag_clear[i]) begin
          flag[i] <= 1'b0;
        end
      end
      wake_up <= |ovf;
    end
  end

  assign counter0_overflow_flag = flag[0];
  assign counter1_overflow_flag = flag[1];
  // Enable gates service in every mode
  assign irq_request = flag & {counter1_irq_enable, counter0_irq_enable};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  for (genvar g = 0; g < 2; g++) begin : gen_chk
    chk_ovf_reload: assert property (ovf[g] |=> count[g] == $past(preload[g]))
      else $error("counter did not reload on overflow");
    chk_flag_set: assert property (ovf[g] |=> flag[g] && wake_up)
      else $error("overflow flag or wake-up missing");
    chk_flag_hold: assert property (flag[g] && !flag_clear[g] |=> flag[g])
      else $error("overflow flag dropped without clear");
    chk_stopped_copy: assert property (pre_wr[g] && !ctrl[g].run
                                       |=> count[g] == $past(pre_val[g]))
      else $error("stopped counter missed preload write");
    chk_running_keep: assert property (pre_wr[g] && ctrl[g].run && !ovf[g]
                                       |=> count[g] != $past(pre_val[g])
                                           || $past(pre_val[g]) == $past(count[g])
                                           || $past(step[g]))
      else $error("running counter overwritten by preload");
    chk_read_block: assert property (value_rd[g] && !pre_wr[g]
                                     |=> $stable(count[g]))
      else $error("counter moved during read");
    chk_stop_hold: assert property (!ctrl[g].run && !pre_wr[g]
                                    |=> $stable(count[g]))
      else $error("stopped counter changed");
    chk_pulse_done: assert property (ctrl[g].mode == dtc_pkg::MODE_PULSE
                                     && pw_active[g] && end_edge[g] && !ctl_wr[g]
                                     |=> !ctrl[g].run ##1 !pw_active[g])
      else $error("pulse measurement did not stop");
    chk_run_kept: assert property (ctrl[g].run && ctrl[g].mode != dtc_pkg::MODE_PULSE
                                   && !ctl_wr[g] |=> ctrl[g].run)
      else $error("run-enable cleared by hardware");
    chk_irq_gate: assert property (irq_request[g] |-> flag[g])
      else $error("interrupt request without flag");
  end

  chk_reserved_zero: assert property (bus_req.rd && (bus_req.addr ==
                                      dtc_pkg::ADDR_C0_CONTROL) |=> (rdata & 8'h27) == 8'h00)
    else $error("reserved control bits read nonzero");

  cov_c0_overflow: cover property (ovf[0] ##1 flag[0]);
  cov_pulse_done:  cover property (pw_active[0] ##1 !ctrl[0].run);
  cov_c1_pair:     cover property (rd_c1_high ##2 rd_c1_low);
  cov_event_step:  cover property (ctrl[0].mode == dtc_pkg::MODE_EVENT && step[0]);

endmodule

`default_nettype wire
